// File: hw/hcp_pkg.sv
// hcp_pkg: offsets, reset values, field positions and carriers of the
// host capability register block.
// assumes a 32-bit APB register window with byte addresses.
`default_nettype none

package hcp_pkg;

   // register byte offsets
   localparam logic [7:0]  HCP_OFS_CAP     = 8'h08;  // host_capability_parameters
   localparam logic [7:0]  HCP_OFS_CMD     = 8'h20;  // host_command_register
   localparam logic [7:0]  HCP_OFS_SEG     = 8'h30;  // pointer bits 63:32
   localparam logic [7:0]  HCP_OFS_PLB     = 8'h34;  // frame list base, bits 31:0
   localparam logic [7:0]  HCP_OFS_ECMD    = 8'h40;  // extended command
   localparam logic [7:0]  HCP_OFS_STAT    = 8'h44;  // block status

   // values after reset
   localparam logic [31:0] HCP_CAP_RESET   = 32'h00016871;
   localparam logic [31:0] HCP_CMD_RESET   = 32'h00080000;
   localparam logic [31:0] HCP_ZERO_WORD   = 32'h00000000;

   // writable bit masks, everything else reads back as stored zero
   localparam logic [31:0] HCP_CMD_WMASK   = 32'h00FF0031;  // frame list size bits kept out
   localparam logic [31:0] HCP_SEG_WMASK   = 32'h00000FFF;  // only pointer bits 43:32 exist
   localparam logic [31:0] HCP_PLB_WMASK   = 32'hFFFFF000;  // 4 KiB aligned base
   localparam logic [31:0] HCP_ECMD_WMASK  = 32'h00000001;

   // capability word fields
   localparam int          HCP_UPD_CAP_BIT = 16;
   localparam int          HCP_XCAP_LSB    = 8;
   localparam logic [7:0]  HCP_XCAP_VAL    = 8'h68;
   localparam int          HCP_IST_LSB     = 4;
   localparam logic [3:0]  HCP_IST_VAL     = 4'h7;
   localparam int          HCP_PARK_BIT    = 2;
   localparam int          HCP_PFL_BIT     = 1;
   localparam int          HCP_A64_BIT     = 0;
   localparam logic [3:0]  HCP_UFR_PER_FRM = 4'h8;   // micro-frames in one frame
   localparam int          HCP_FRAME_LEN   = 1024;   // fixed frame list elements
   localparam int          HCP_ADDR_BITS   = 44;     // implemented pointer bits

   // command, extended command and status fields
   localparam int          HCP_FLS_LSB     = 2;
   localparam int          HCP_RUN_BIT     = 0;
   localparam int          HCP_PUE_BIT     = 0;
   localparam int          HCP_ST_RUN_BIT  = 0;
   localparam int          HCP_ST_PUE_BIT  = 1;
   localparam int          HCP_ST_PTR_BIT  = 2;
   localparam int          HCP_ST_ISO_LSB  = 4;
   localparam int          HCP_ST_A64_BIT  = 8;

   // bus transfer phase of the slave
   typedef enum logic [1:0]
   {
      HCP_IDLE   = 2'b00,
      HCP_ANSWER = 2'b01
   } hcp_state_t;

   // apb request as seen by the slave
   typedef struct packed
   {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } hcp_apb_req_t;

   // apb answer, held in flops
   typedef struct packed
   {
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
   } hcp_apb_rsp_t;

endpackage

`default_nettype wire

// File: hw/hcp_cap_word.sv
// hcp_cap_word: composes the hardwired capability word and derives the
// isochronous hold depth from its threshold field.
// assumes nothing: pure combinational constants.
`timescale 1ns/1ps
`default_nettype none

module hcp_cap_word
   import hcp_pkg::*;
(
   output logic [31:0] cap_word,
   output logic [3:0]  iso_hold
);

   // capability word built field by field over a zero base
   always_comb
   begin
      cap_word                        = HCP_ZERO_WORD;  // reserved bits stay zero
      cap_word[HCP_UPD_CAP_BIT]       = 1'b1;           // periodic update supported
      cap_word[HCP_XCAP_LSB +: 8]     = HCP_XCAP_VAL;   // extended capability start
      cap_word[HCP_IST_LSB +: 4]      = HCP_IST_VAL;    // scheduling threshold
      cap_word[HCP_PARK_BIT]          = 1'b0;           // no async park
      cap_word[HCP_PFL_BIT]           = 1'b0;           // frame list length fixed
      cap_word[HCP_A64_BIT]           = 1'b1;           // 64-bit structures
   end

   // hold depth in micro-frames: low three bits, or a whole frame
   always_comb
   begin
      if (HCP_IST_VAL[3])
      begin
         iso_hold = HCP_UFR_PER_FRM;                    // caches a whole frame
      end
      else
      begin
         iso_hold = {1'b0, HCP_IST_VAL[2:0]};           // bounded micro-frames
      end
   end

endmodule

`default_nettype wire

// File: hw/hcp_ptr_trim.sv
// hcp_ptr_trim: cuts a 64-bit structure pointer to the implemented
// address bits and flags whether the dropped bits were clear.
// assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module hcp_ptr_trim
   import hcp_pkg::*;
#(
   parameter int IMPL_BITS = HCP_ADDR_BITS
)
(
   input  wire logic [63:0]          ptr,
   output logic      [IMPL_BITS-1:0] addr,
   output logic                      high_clear
);

   // upper pointer bits never reach the address
   assign addr       = ptr[IMPL_BITS-1:0];

   // true when software kept the unimplemented bits at zero
   assign high_clear = (ptr[63:IMPL_BITS] == '0);

endmodule

`default_nettype wire

// File: hw/hcp_regs.sv
// hcp_regs: apb register slave holding the host capability parameters
// word plus the command, pointer and status words it governs.
// assumes apb signals synchronous to CLK_SYS and one word per address.
//
// What this block does
// - capability bit 16 reads one
// - bits 15:8 read constant 68h
// - threshold field bits 7:4 reads 7h
// - threshold sets micro-frame or whole-frame hold
// - async park bit 2 reads zero
// - command frame list size bits read zero
// - bit 0 reads one for 64-bit pointers
// - only 44 pointer bits, upper bits zero
// - reserved bits 31:17 and 3 zero
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module hcp_regs
   import hcp_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             HC_RUN,
   output logic             PERIODIC_UPDATE_EN,
   output logic      [43:0] FRAME_LIST_ADDR,
   output logic      [3:0]  ISO_HOLD_UFRAMES,
   output logic             ADDR_64BIT
);

   // bus request gathered into one carrier
   hcp_apb_req_t req;
   // answer flops
   hcp_apb_rsp_t rsp_q;
   // transfer phase
   hcp_state_t   state_q;

   // software registers
   logic [31:0]  cmd_q;        // host command word
   logic [31:0]  seg_q;        // pointer bits 63:32
   logic [31:0]  plb_q;        // frame list base bits 31:0
   logic [31:0]  ecmd_q;       // extended command word

   // derived state, registered for the outputs
   logic [43:0]  fladdr_q;     // trimmed frame list address
   logic         ptr_ok_q;     // dropped pointer bits were zero
   logic [3:0]   iso_q;        // isochronous hold depth
   logic         a64_q;        // 64-bit structure mode

   // combinational helpers
   logic [31:0]  cap_word;     // hardwired capability word
   logic [3:0]   iso_hold;     // hold depth from threshold
   logic [43:0]  trim_addr;    // pointer cut to 44 bits
   logic         trim_ok;      // high pointer bits clear
   logic [31:0]  stat_word;    // status as read
   logic [31:0]  rd_word;      // read mux result
   logic         rd_hit;       // address decodes to a register
   logic         setup;        // first cycle of a transfer
   logic         wr_fire;      // write completes this edge
   logic         rd_fire;      // read completes this edge

   assign req.sel    = PSEL;
   assign req.enable = PENABLE;
   assign req.write  = PWRITE;
   assign req.addr   = PADDR;
   assign req.wdata  = PWDATA;

   // transfer events
   assign setup   = req.sel & ~req.enable;
   assign wr_fire = req.sel & req.enable & rsp_q.ready & req.write;
   assign rd_fire = req.sel & req.enable & rsp_q.ready & ~req.write;

   // capability word source
   hcp_cap_word u_cap
   (
      .cap_word (cap_word),
      .iso_hold (iso_hold)
   );

   // frame list pointer trimmed to the implemented width
   hcp_ptr_trim #(.IMPL_BITS(HCP_ADDR_BITS)) u_trim
   (
      .ptr        ({seg_q, plb_q}),
      .addr       (trim_addr),
      .high_clear (trim_ok)
   );

   // status word: block state visible to software
   always_comb
   begin
      stat_word                      = HCP_ZERO_WORD;
      stat_word[HCP_ST_RUN_BIT]      = cmd_q[HCP_RUN_BIT];
      stat_word[HCP_ST_PUE_BIT]      = ecmd_q[HCP_PUE_BIT];
      stat_word[HCP_ST_PTR_BIT]      = ptr_ok_q;
      stat_word[HCP_ST_ISO_LSB +: 4] = iso_q;
      stat_word[HCP_ST_A64_BIT]      = a64_q;
   end

   // read mux; unmapped addresses read zero and flag an error
   always_comb
   begin
      rd_word = HCP_ZERO_WORD;
      rd_hit  = 1'b1;
      case (req.addr)
         HCP_OFS_CAP:  rd_word = cap_word;    // same constant every read
         HCP_OFS_CMD:  rd_word = cmd_q;
         HCP_OFS_SEG:  rd_word = seg_q;
         HCP_OFS_PLB:  rd_word = plb_q;
         HCP_OFS_ECMD: rd_word = ecmd_q;
         HCP_OFS_STAT: rd_word = stat_word;
         default:      rd_hit  = 1'b0;
      endcase
   end

   // transfer phase: answer is given in the first access cycle
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         state_q <= HCP_IDLE;
      end
      else
      begin
         case (state_q)
            HCP_IDLE:
            begin
               if (setup)
               begin
                  state_q <= HCP_ANSWER;
               end
            end
            HCP_ANSWER:
            begin
               if (req.sel & req.enable)
               begin
                  state_q <= HCP_IDLE;
               end
            end
            default:
            begin
               state_q <= HCP_IDLE;
            end
         endcase
      end
   end

   // answer flops, loaded at the setup edge, held for one access cycle
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         rsp_q <= '0;
      end
      else if (setup && state_q == HCP_IDLE)
      begin
         rsp_q.ready  <= 1'b1;
         rsp_q.slverr <= ~rd_hit;
         rsp_q.rdata  <= req.write ? HCP_ZERO_WORD : rd_word;
      end
      else
      begin
         rsp_q <= '0;
      end
   end

   // command word; frame list size field never stored
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         cmd_q <= HCP_CMD_RESET;
      end
      else if (wr_fire && req.addr == HCP_OFS_CMD)
      begin
         cmd_q <= req.wdata & HCP_CMD_WMASK;   // bits 3:2 masked to zero
      end
   end

   // pointer segment: bits above 43 cannot be stored
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         seg_q <= HCP_ZERO_WORD;
      end
      else if (wr_fire && req.addr == HCP_OFS_SEG)
      begin
         seg_q <= req.wdata & HCP_SEG_WMASK;
      end
   end

   // frame list base: low 12 bits forced clear for a page-aligned list
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         plb_q <= HCP_ZERO_WORD;
      end
      else if (wr_fire && req.addr == HCP_OFS_PLB)
      begin
         plb_q <= req.wdata & HCP_PLB_WMASK;
      end
   end

   // extended command: periodic update enable exists since it is advertised
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         ecmd_q <= HCP_ZERO_WORD;
      end
      else if (wr_fire && req.addr == HCP_OFS_ECMD)
      begin
         ecmd_q <= req.wdata & HCP_ECMD_WMASK;
      end
   end

   // derived state registered for clean outputs
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         fladdr_q <= '0;
         ptr_ok_q <= 1'b0;
         iso_q    <= 4'h0;
         a64_q    <= 1'b0;
      end
      else
      begin
         fladdr_q <= trim_addr;                // 44-bit address
         ptr_ok_q <= trim_ok;
         iso_q    <= iso_hold;
         a64_q    <= cap_word[HCP_A64_BIT];
      end
   end

   // outputs straight from flops
   assign PRDATA             = rsp_q.rdata;
   assign PREADY             = rsp_q.ready;
   assign PSLVERR            = rsp_q.slverr;
   assign HC_RUN             = cmd_q[HCP_RUN_BIT];
   assign PERIODIC_UPDATE_EN = ecmd_q[HCP_PUE_BIT];
   assign FRAME_LIST_ADDR    = fladdr_q;
   assign ISO_HOLD_UFRAMES   = iso_q;
   assign ADDR_64BIT         = a64_q;

   // checks on the answers seen by software
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   // capability read helper
   logic cap_rd;
   assign cap_rd = rd_fire && req.addr == HCP_OFS_CAP;

   a_upd_cap_bit: assert property (cap_rd |-> PRDATA[HCP_UPD_CAP_BIT] == 1'b1)
      else $error("periodic update capability bit not one");

   a_xcap_field: assert property (cap_rd |-> PRDATA[HCP_XCAP_LSB +: 8] == 8'h68)
      else $error("extended capability pointer wrong");

   a_ist_field: assert property (cap_rd |-> PRDATA[HCP_IST_LSB +: 4] == 4'h7)
      else $error("scheduling threshold wrong");

   a_iso_hold_depth: assert property ($past(NRST) |-> ISO_HOLD_UFRAMES == 4'h7)
      else $error("isochronous hold depth wrong");

   a_park_zero: assert property (cap_rd |-> !PRDATA[HCP_PARK_BIT] && !PRDATA[HCP_PFL_BIT])
      else $error("async park or frame list flag set");

   a_fls_zero: assert property (wr_fire && req.addr == HCP_OFS_CMD |=> cmd_q[3:2] == 2'b00)
      else $error("frame list size field took a write");

   a_list_align: assert property (FRAME_LIST_ADDR[11:0] == 12'h000)
      else $error("frame list address not page aligned");

   a_addr64_bit: assert property (cap_rd |-> PRDATA[HCP_A64_BIT] && ADDR_64BIT)
      else $error("64-bit capability not reported");

   a_ptr_upper: assert property (rd_fire && req.addr == HCP_OFS_SEG |-> PRDATA[31:12] == 20'h00000)
      else $error("pointer bits above 43 readable");

   a_resv_zero: assert property (cap_rd |-> PRDATA[31:17] == 15'h0000 && !PRDATA[3])
      else $error("reserved capability bits not zero");

   a_cap_const: assert property (cap_rd |-> PRDATA == 32'h00016871 && !PSLVERR)
      else $error("capability word not the constant");

   a_cap_write_nop: assert property (wr_fire && req.addr == HCP_OFS_CAP
                                     |=> $stable(cmd_q) && $stable(seg_q) && $stable(plb_q)
                                         && $stable(ecmd_q) ##1 cap_word == HCP_CAP_RESET)
      else $error("capability write changed state");

   a_ready_next: assert property (setup && state_q == HCP_IDLE |=> PREADY ##1 !PREADY)
      else $error("ready not one cycle after setup");

   c_cap_read: cover property (cap_rd);
   c_cmd_write: cover property (wr_fire && req.addr == HCP_OFS_CMD);
   c_unmapped: cover property (req.sel && req.enable && PREADY && PSLVERR);
   c_back2back: cover property (rd_fire ##1 setup);

endmodule

`default_nettype wire

// File: testbench/hcp_tb.sv
// testbench: self-checking bench for the host capability register slave.
// assumes hcp_regs answers apb with zero wait states; the master still waits for pready.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import hcp_pkg::*;

   logic        clk_sys;            // system clock, 10 ns
   logic        nrst;               // synchronous reset, active low
   logic        psel;               // apb select
   logic        penable;            // apb access phase
   logic        pwrite;             // apb direction
   logic [7:0]  paddr;              // apb byte address
   logic [31:0] pwdata;             // apb write data
   logic [31:0] prdata;             // apb read data
   logic        pready;             // apb ready
   logic        pslverr;            // apb error
   logic        hc_run;             // command run bit
   logic        periodic_update_en; // extended command enable
   logic [43:0] frame_list_addr;    // trimmed frame list pointer
   logic [3:0]  iso_hold_uframes;   // isochronous hold depth
   logic        addr_64bit;         // 64-bit structure mode
   int          n_mismatch;         // mismatches seen
   int          comparisons;        // comparisons made
   logic [31:0] rd;                 // last read data
   logic        err;                // last error flag
   logic        b2b;                // next transfer follows at once
   logic        chained;            // this transfer follows the last at once

   // device under test, every input driven by the bench
   hcp_regs u_dut
   (
      .CLK_SYS            (clk_sys),
      .NRST               (nrst),
      .PSEL               (psel),
      .PENABLE            (penable),
      .PWRITE             (pwrite),
      .PADDR              (paddr),
      .PWDATA             (pwdata),
      .PRDATA             (prdata),
      .PREADY             (pready),
      .PSLVERR            (pslverr),
      .HC_RUN             (hc_run),
      .PERIODIC_UPDATE_EN (periodic_update_en),
      .FRAME_LIST_ADDR    (frame_list_addr),
      .ISO_HOLD_UFRAMES   (iso_hold_uframes),
      .ADDR_64BIT         (addr_64bit)
   );

   // free-running clock
   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   // prints the counts and the verdict, then ends the run
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // four-state compare with a one-line report on mismatch
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic erf);
      int i;
      if (!chained)
         @(posedge clk_sys);        // idle cycle unless chained
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_sys);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         n_mismatch++;
         $display("[FAIL] %0t no ready from slave", $time);
         finish_test();
      end
      rdat    = prdata;
      erf     = pslverr;
      chained = b2b;
      b2b     = 1'b0;
      // a chained transfer keeps the bus; the next setup lowers penable
      if (!chained)
      begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // read and compare data and error flag
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h00000000, rd, err);
      check({32'h00000000, rd}, {32'h00000000, exp}, "read data");
      check({63'h0, err}, {63'h0, exp_err}, "error flag");
   endtask

   // write and check the error flag
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] wd, input logic exp_err);
      apb(1'b1, a, wd, rd, err);
      check({63'h0, err}, {63'h0, exp_err}, "write error flag");
   endtask

   // apply reset for a number of cycles
   task automatic do_reset(input int n);
      nrst <= 1'b0;
      repeat (n) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
   endtask

   // main sequence
   initial
   begin
      n_mismatch  = 0;
      comparisons = 0;
      b2b         = 1'b0;
      chained     = 1'b0;
      nrst        = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h00000000;
      do_reset(12);
      // capability word as a whole, then field by field
      rd_chk(HCP_OFS_CAP, 32'h00016871, 1'b0);
      check({63'h0, rd[16]}, 64'h1, "update capability bit");
      check({56'h0, rd[15:8]}, 64'h68, "extended capability offset");
      check({60'h0, rd[7:4]}, 64'h7, "threshold field");
      check({62'h0, rd[3:2]}, 64'h0, "reserved and park bits");
      check({62'h0, rd[1:0]}, 64'h1, "frame list flag and 64-bit bit");
      check({49'h0, rd[31:17]}, 64'h0, "upper reserved bits");
      // threshold top bit clear, so hold depth is the low three bits
      check({60'h0, iso_hold_uframes}, 64'h7, "hold depth");
      check({63'h0, addr_64bit}, 64'h1, "64-bit mode");
      // writes of all ones and all zeros leave the word untouched
      wr_chk(HCP_OFS_CAP, 32'hFFFFFFFF, 1'b0);
      rd_chk(HCP_OFS_CAP, 32'h00016871, 1'b0);
      wr_chk(HCP_OFS_CAP, 32'h00000000, 1'b0);
      rd_chk(HCP_OFS_CAP, 32'h00016871, 1'b0);
      // command register: reset value, size field stays zero
      rd_chk(HCP_OFS_CMD, 32'h00080000, 1'b0);
      wr_chk(HCP_OFS_CMD, 32'hFFFFFFFF, 1'b0);
      rd_chk(HCP_OFS_CMD, 32'h00FF0031, 1'b0);
      check({63'h0, hc_run}, 64'h1, "run output");
      // pointer halves: only 44 bits, base on a 4K boundary
      wr_chk(HCP_OFS_SEG, 32'hFFFFFFFF, 1'b0);
      rd_chk(HCP_OFS_SEG, 32'h00000FFF, 1'b0);
      wr_chk(HCP_OFS_PLB, 32'hABCDE000, 1'b0);
      rd_chk(HCP_OFS_PLB, 32'hABCDE000, 1'b0);
      @(posedge clk_sys);
      check({20'h0, frame_list_addr}, 64'h00000FFFABCDE000, "frame list pointer");
      // extended command enable reaches its output
      wr_chk(HCP_OFS_ECMD, 32'hFFFFFFFF, 1'b0);
      rd_chk(HCP_OFS_ECMD, 32'h00000001, 1'b0);
      check({63'h0, periodic_update_en}, 64'h1, "update enable output");
      // back-to-back reads: next setup right after the completing edge
      b2b = 1'b1;
      rd_chk(HCP_OFS_CAP, 32'h00016871, 1'b0);
      rd_chk(HCP_OFS_ECMD, 32'h00000001, 1'b0);
      // status: run, enable, upper pointer bits zero, depth 7, 64-bit mode
      rd_chk(HCP_OFS_STAT, 32'h00000177, 1'b0);
      // unmapped address refused, capability still intact
      rd_chk(8'h0C, 32'h00000000, 1'b1);
      wr_chk(8'h0C, 32'hFFFFFFFF, 1'b1);
      rd_chk(HCP_OFS_CAP, 32'h00016871, 1'b0);
      // second reset in mid-run restores command, capability unchanged
      do_reset(2);
      rd_chk(HCP_OFS_CMD, 32'h00080000, 1'b0);
      rd_chk(HCP_OFS_CAP, 32'h00016871, 1'b0);
      check({60'h0, iso_hold_uframes}, 64'h7, "hold depth after reset");
      finish_test();
   end

endmodule

`default_nettype wire
